/* core/lgcir_regs.sv */
// global clock rate select and channel 0 interrupt status registers
module lgcir_regs #(
  // bus widths, fixed by the request carrier
  parameter int BUS_ADDR_W = lgcir_pkg::ADDR_W,
  parameter int BUS_DATA_W = lgcir_pkg::DATA_W
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // register access
  input wire lgcir_pkg::lgcir_req_t i_req,
  output logic [BUS_DATA_W-1:0] o_rdata,
  output logic o_rvalid,
  // channel 0 interrupt event
  input wire logic i_chan_zero_irq,
  // decoded reference rate
  output lgcir_pkg::lgcir_rate_t o_ref_rate,
  output logic o_rate_reserved,
  output logic [3:0] o_ref_rate_code
);
  import lgcir_pkg::*;

  // refuse widths the request carrier cannot serve
  if (BUS_ADDR_W != ADDR_W) begin : g_addr_w_chk
    $error("address width must match the request carrier");
  end
  if (BUS_DATA_W != DATA_W) begin : g_data_w_chk
    $error("data width must match the request carrier");
  end

  logic [3:0] ref_rate_code_reg;
  logic chan_zero_irq_flag_reg;
  logic [BUS_DATA_W-1:0] rdata_next;
  lgcir_rate_t rate_next;
  logic reserved_next;
  logic sel_clk;
  logic sel_irq;

  assign sel_clk = (i_req.addr == CLK_SEL_ADDR);
  assign sel_irq = (i_req.addr == IRQ_STAT_ADDR);

  // rate code register
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ref_rate_code_reg <= RATE_CODE_RESET;
    end else if (i_req.wr && sel_clk) begin
      ref_rate_code_reg <= i_req.wdata[RATE_LSB +: RATE_W];
    end
  end

  // sticky interrupt flag, set wins over read clear
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      chan_zero_irq_flag_reg <= IRQ_STAT_RESET[IRQ_BIT];
    end else if (i_chan_zero_irq) begin
      chan_zero_irq_flag_reg <= 1'b1;
    end else if (i_req.rd && sel_irq) begin
      chan_zero_irq_flag_reg <= 1'b0;
    end
  end

  // read data
  always_comb begin
    rdata_next = '0;
    if (sel_clk) begin
      rdata_next = BUS_DATA_W'(ref_rate_code_reg);
    end else if (sel_irq) begin
      rdata_next = BUS_DATA_W'(chan_zero_irq_flag_reg);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_rdata <= '0;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_req.rd;
      if (i_req.rd) begin
        o_rdata <= rdata_next;
      end
    end
  end

  // rate decode
  always_comb begin
    reserved_next = 1'b0;
    rate_next = LGCIR_R2048;
    case (ref_rate_code_reg)
      4'h0, 4'hE: rate_next = LGCIR_R2048;
      4'h1, 4'hF: rate_next = LGCIR_R1544;
      4'h8: rate_next = LGCIR_R4096;
      4'h9: rate_next = LGCIR_R3088;
      4'hA: rate_next = LGCIR_R8192;
      4'hB: rate_next = LGCIR_R6176;
      4'hC: rate_next = LGCIR_R16384;
      4'hD: rate_next = LGCIR_R12352;
      default: reserved_next = 1'b1;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_ref_rate <= LGCIR_R1544;
      o_rate_reserved <= 1'b0;
      o_ref_rate_code <= RATE_CODE_RESET;
    end else begin
      o_ref_rate <= rate_next;
      o_rate_reserved <= reserved_next;
      o_ref_rate_code <= ref_rate_code_reg;
    end
  end

  // assertions
  rate_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_req.wr && sel_clk) |=> (ref_rate_code_reg == $past(i_req.wdata[RATE_LSB +: RATE_W])))
    else $error("rate code not written");
  rate_reset_a: assert property (@(posedge i_clk)
    !i_resetn |=> (ref_rate_code_reg == RATE_CODE_RESET))
    else $error("rate code reset wrong");
  rate_decode_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (ref_rate_code_reg == 4'hC) |=> (o_ref_rate == LGCIR_R16384))
    else $error("rate decode wrong");
  decode_2048_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (ref_rate_code_reg inside {4'h0, 4'hE}) |=> (o_ref_rate == LGCIR_R2048))
    else $error("rate decode 2048 wrong");
  decode_1544_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (ref_rate_code_reg inside {4'h1, 4'hF}) |=> (o_ref_rate == LGCIR_R1544))
    else $error("rate decode 1544 wrong");
  decode_4096_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (ref_rate_code_reg == 4'h8) |=> (o_ref_rate == LGCIR_R4096))
    else $error("rate decode 4096 wrong");
  decode_3088_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (ref_rate_code_reg == 4'h9) |=> (o_ref_rate == LGCIR_R3088))
    else $error("rate decode 3088 wrong");
  decode_8192_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (ref_rate_code_reg == 4'hA) |=> (o_ref_rate == LGCIR_R8192))
    else $error("rate decode 8192 wrong");
  decode_6176_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (ref_rate_code_reg == 4'hB) |=> (o_ref_rate == LGCIR_R6176))
    else $error("rate decode 6176 wrong");
  decode_12352_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (ref_rate_code_reg == 4'hD) |=> (o_ref_rate == LGCIR_R12352))
    else $error("rate decode 12352 wrong");
  rate_rsvd_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (ref_rate_code_reg inside {[4'h2:4'h7]}) |=> o_rate_reserved)
    else $error("reserved code not flagged");
  irq_set_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_chan_zero_irq |=> chan_zero_irq_flag_reg)
    else $error("irq flag not set");
  read_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_req.rd && sel_irq && !i_chan_zero_irq) |=> !chan_zero_irq_flag_reg)
    else $error("irq flag not cleared by read");
  read_value_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_req.rd && sel_irq) |=> (o_rdata[0] == $past(chan_zero_irq_flag_reg)) && o_rvalid)
    else $error("status read value wrong");
  rsvd_zero_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_req.rd && sel_irq) |=> (o_rdata[7:1] == 7'h00))
    else $error("reserved status bits nonzero");
  set_wins_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_req.rd && sel_irq && i_chan_zero_irq) |=> chan_zero_irq_flag_reg)
    else $error("event lost on read");

  // values after reset
  flag_reset_a: assert property (@(posedge i_clk)
    !i_resetn |=> !chan_zero_irq_flag_reg)
    else $error("irq flag reset wrong");
  rvalid_reset_a: assert property (@(posedge i_clk)
    !i_resetn |=> (!o_rvalid && (o_rdata == '0)))
    else $error("read answer reset wrong");
  rate_out_reset_a: assert property (@(posedge i_clk)
    !i_resetn |=> ((o_ref_rate == LGCIR_R1544) && !o_rate_reserved))
    else $error("decoded rate reset wrong");
  code_out_reset_a: assert property (@(posedge i_clk)
    !i_resetn |=> (o_ref_rate_code == RATE_CODE_RESET))
    else $error("rate code output reset wrong");

  // bus answer and holding
  rvalid_pulse_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_req.rd |=> o_rvalid)
    else $error("read not answered");
  rvalid_idle_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !i_req.rd |=> !o_rvalid)
    else $error("answer without read");
  rdata_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !i_req.rd |=> $stable(o_rdata))
    else $error("read data moved without read");
  unmapped_zero_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_req.rd && !sel_clk && !sel_irq) |=> (o_rdata == '0))
    else $error("unmapped read not zero");
  code_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !(i_req.wr && sel_clk) |=> $stable(ref_rate_code_reg))
    else $error("rate code moved without write");
  clk_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_req.rd && sel_clk) |=> (o_rdata[3:0] == $past(ref_rate_code_reg)) && (o_rdata[7:4] == 4'h0))
    else $error("clock select read wrong");
  flag_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (!i_chan_zero_irq && !(i_req.rd && sel_irq)) |=> $stable(chan_zero_irq_flag_reg))
    else $error("irq flag moved without cause");
  code_mirror_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    1'b1 |=> (o_ref_rate_code == $past(ref_rate_code_reg)))
    else $error("rate code output wrong");
  rate_onehot_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $onehot(o_ref_rate))
    else $error("decoded rate not one-hot");
  rsvd_default_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_rate_reserved |-> (o_ref_rate == LGCIR_R2048))
    else $error("reserved code rate wrong");
  rate_norsvd_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !(ref_rate_code_reg inside {[4'h2:4'h7]}) |=> !o_rate_reserved)
    else $error("valid code flagged reserved");

  irq_read_c: cover property (@(posedge i_clk) disable iff (!i_resetn)
    chan_zero_irq_flag_reg && i_req.rd && sel_irq);
  collide_c: cover property (@(posedge i_clk) disable iff (!i_resetn)
    i_chan_zero_irq && i_req.rd && sel_irq);
  rate_wr_c: cover property (@(posedge i_clk) disable iff (!i_resetn)
    i_req.wr && sel_clk ##1 i_req.rd && sel_clk);
  rsvd_code_c: cover property (@(posedge i_clk) disable iff (!i_resetn)
    o_rate_reserved);
  clk_read_c: cover property (@(posedge i_clk) disable iff (!i_resetn)
    i_req.rd && sel_clk);
endmodule

/* core/lgcir_pkg.sv */
// package for the global clock select and channel interrupt register pair
package lgcir_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] CLK_SEL_ADDR = 16'h0FE9;
  localparam logic [15:0] IRQ_STAT_ADDR = 16'h0FEA;
  localparam logic [3:0] RATE_CODE_RESET = 4'h1;
  localparam logic [7:0] IRQ_STAT_RESET = 8'h00;
  localparam int RATE_LSB = 0;
  localparam int RATE_W = 4;
  localparam int IRQ_BIT = 0;

  typedef enum logic [7:0] {
    LGCIR_R2048 = 8'h01,
    LGCIR_R1544 = 8'h02,
    LGCIR_R4096 = 8'h04,
    LGCIR_R3088 = 8'h08,
    LGCIR_R8192 = 8'h10,
    LGCIR_R6176 = 8'h20,
    LGCIR_R16384 = 8'h40,
    LGCIR_R12352 = 8'h80
  } lgcir_rate_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } lgcir_req_t;
endpackage

/* dv/lgcir_regs_tb_top.sv */
// self-checking bench for the clock select and channel 0 interrupt registers
module lgcir_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lgcir_pkg::*;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  lgcir_req_t i_req = '0;
  logic i_chan_zero_irq = 1'b0;
  logic [7:0] o_rdata;
  logic o_rvalid;
  lgcir_rate_t o_ref_rate;
  logic o_rate_reserved;
  logic [3:0] o_ref_rate_code;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  typedef struct packed {logic [3:0] code; logic [7:0] rate; logic rsvd;} lgcir_row_t;
  // rate code, expected one-hot rate, expected reserved flag
  lgcir_row_t rows [16] = '{{4'h0, 8'h01, 1'b0}, {4'h1, 8'h02, 1'b0}, {4'h2, 8'h01, 1'b1},
    {4'h3, 8'h01, 1'b1}, {4'h4, 8'h01, 1'b1}, {4'h5, 8'h01, 1'b1}, {4'h6, 8'h01, 1'b1},
    {4'h7, 8'h01, 1'b1}, {4'h8, 8'h04, 1'b0}, {4'h9, 8'h08, 1'b0}, {4'hA, 8'h10, 1'b0},
    {4'hB, 8'h20, 1'b0}, {4'hC, 8'h40, 1'b0}, {4'hD, 8'h80, 1'b0}, {4'hE, 8'h01, 1'b0},
    {4'hF, 8'h02, 1'b0}};
  lgcir_regs dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_req(i_req), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .i_chan_zero_irq(i_chan_zero_irq), .o_ref_rate(o_ref_rate),
    .o_rate_reserved(o_rate_reserved), .o_ref_rate_code(o_ref_rate_code));
  always #12.5 i_clk = ~i_clk;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, s);
      error_cnt++;
    end
  endtask
  // one access, irq event driven in the same cycle
  task automatic acc(input logic r, input logic [15:0] a, input logic [7:0] d, input logic q);
    @(posedge i_clk);
    i_req <= '{rd: r, wr: ~r, addr: a, wdata: d};
    i_chan_zero_irq <= q;
    @(posedge i_clk);
    i_req <= '0;
    i_chan_zero_irq <= 1'b0;
    @(negedge i_clk);
    if (r) chk("rvalid", {7'h00, o_rvalid}, 8'h01);
  endtask
  initial begin
    repeat (20) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(negedge i_clk);
    chk("rate code", {4'h0, o_ref_rate_code}, 8'h01);
    chk("rate", o_ref_rate, 8'h02);
    acc(1'b1, IRQ_STAT_ADDR, 8'h00, 1'b0);
    chk("status", o_rdata, 8'h00);
    $display("reset test done");
    for (int c = 0; c < 16; c++) begin
      acc(1'b0, CLK_SEL_ADDR, {4'hF, rows[c].code}, 1'b0);
      acc(1'b1, CLK_SEL_ADDR, 8'h00, 1'b0);
      chk("sel read", o_rdata, {4'h0, rows[c].code});
      chk("rate", o_ref_rate, rows[c].rate);
      chk("reserved", {7'h00, o_rate_reserved}, {7'h00, rows[c].rsvd});
    end
    $display("rate code table done");
    acc(1'b0, 16'h0FE8, 8'h0C, 1'b1);
    acc(1'b1, 16'h0FEB, 8'h00, 1'b0);
    chk("unmapped", o_rdata, 8'h00);
    chk("code kept", {4'h0, o_ref_rate_code}, 8'h0F);
    acc(1'b0, IRQ_STAT_ADDR, 8'hFF, 1'b0);
    acc(1'b1, IRQ_STAT_ADDR, 8'h00, 1'b1);
    chk("status set", o_rdata, 8'h01);
    acc(1'b1, IRQ_STAT_ADDR, 8'h00, 1'b0);
    chk("status kept", o_rdata, 8'h01);
    acc(1'b1, IRQ_STAT_ADDR, 8'h00, 1'b0);
    chk("status clear", o_rdata, 8'h00);
    $display("interrupt status test done");
    acc(1'b0, CLK_SEL_ADDR, 8'h0C, 1'b1);
    @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(negedge i_clk);
    chk("code after reset", {4'h0, o_ref_rate_code}, 8'h01);
    chk("rate after reset", o_ref_rate, 8'h02);
    acc(1'b1, IRQ_STAT_ADDR, 8'h00, 1'b0);
    chk("status after reset", o_rdata, 8'h00);
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule
